/* File: src/cmc_channel.sv */
// Compare match channel with Avalon-MM registers, pin logic and interrupts
`timescale 1ns/10ps
//
// Contract
// - Compare value checked against selected timer in the five compare modes only
// - Match drives pin high, low, toggle, unchanged
// - Event flag set with the pin action
// - Mode 1010: interrupt only, pin untouched
// - Mode 1011: special event trigger pulse on match
// - Trigger resets the currently selected timer pair
// - This trigger never starts a conversion
// - Control written zero clears output latch
// - PWM mode with up to 10-bit duty
// - Unimplemented bits read zero; duty 5:4, mode 3:0
// - Select 00 first, 01/10 second, 11 reserved
// - Event flag at bit 1, software clears
module cmc_channel
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Timer pairs and time base
   input wire logic [15:0] first_timer_pair,
   input wire logic [15:0] second_timer_pair,
   input wire cmc_pkg::cmc_pwm_time_s pwm_time,
   output logic first_timer_reset,
   output logic second_timer_reset,
   output logic special_event_trigger,
   // Channel output pin
   input wire logic port_data_latch,
   input wire logic pin_direction_bit,
   output logic channel_output_pin,
   output logic channel_output_pin_oe,
   // Interrupts
   output logic channel_event_irq,
   output logic channel_event_high_prio,
   output logic irq
);
   import cmc_pkg::*;

   cmc_state_s s_r;
   cmc_state_s s_nxt;
   logic req;
   logic go;
   logic wr_go;
   logic rd_go;
   logic hit;
   logic pwm_level;
   logic [3:0] mode;
   logic use_second;
   logic act;
   logic [7:0] wbyte;

   assign req = avs_read | avs_write;
   assign go = req && !s_r.wait_r;
   assign wr_go = go && avs_write && avs_byteenable[0];
   assign rd_go = go && avs_read;
   assign mode = s_r.ctrl[3:0];
   assign use_second = cmc_use_second(s_r.tsel_a[1:0]);
   assign act = hit && cmc_is_compare(mode);
   assign wbyte = avs_writedata[7:0];

   // Outputs straight from the state register
   assign avs_readdata = s_r.rdata;
   assign avs_waitrequest = s_r.wait_r;
   assign first_timer_reset = s_r.first_rst;
   assign second_timer_reset = s_r.second_rst;
   assign special_event_trigger = s_r.trig;
   assign channel_output_pin = s_r.pin;
   assign channel_output_pin_oe = s_r.pin_oe;
   assign channel_event_irq = s_r.chan_int;
   assign channel_event_high_prio = s_r.chan_prio;
   assign irq = s_r.irq;

   // Compare value against the selected timer
   cmc_match_detect u_detect
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .enable(cmc_is_compare(mode)),
      .compare_value({s_r.cmp_hi, s_r.cmp_lo}),
      .first_count(first_timer_pair),
      .second_count(second_timer_pair),
      .use_second(use_second),
      .hit(hit)
   );

   // PWM path; duty is the low compare byte (cmp_lo) plus two control bits
   cmc_pwm_gen u_pwm
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .enable(cmc_is_pwm(mode)),
      .duty({s_r.cmp_lo, s_r.ctrl[CMC_DUTY_LSB+1:CMC_DUTY_LSB]}),
      .pwm_time(pwm_time),
      .level(pwm_level)
   );

   // Read multiplexer; unmapped addresses read zero
   function automatic logic [7:0] rd_mux(input logic [7:0] a, input cmc_state_s st);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         CMC_OFF_CMP_LO: v = st.cmp_lo;
         CMC_OFF_CMP_HI: v = st.cmp_hi;
         CMC_OFF_CTRL: v = st.ctrl & CMC_CTRL_MASK;
         CMC_OFF_TSEL_A: v = st.tsel_a & CMC_TSEL_A_MASK;
         CMC_OFF_TSEL_B: v = st.tsel_b & CMC_TSEL_B_MASK;
         CMC_OFF_FLAGS: v = st.flags & CMC_CHAN_MASK;
         CMC_OFF_ENABLES: v = st.enables & CMC_CHAN_MASK;
         CMC_OFF_PRIOS: v = st.prios & CMC_CHAN_MASK;
         CMC_OFF_IRQ_STAT: v = {6'h00, st.irq_stat};
         CMC_OFF_IRQ_MASK: v = {6'h00, st.irq_mask};
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // Next state: bus, match actions, pin and interrupt outputs
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.trig = 1'b0;
      s_nxt.first_rst = 1'b0;
      s_nxt.second_rst = 1'b0;
      // One wait cycle per access; answer at the following edge
      s_nxt.wait_r = !(req && s_r.wait_r);
      if (req && s_r.wait_r)
         s_nxt.rdata = {24'h000000, rd_mux(avs_address, s_r)};
      // Pin action before the bus write so a clearing write has the last word
      if (act)
      begin
         unique case (mode)
            CMC_MODE_SET_HIGH: s_nxt.latch = 1'b1;
            CMC_MODE_SET_LOW: s_nxt.latch = 1'b0;
            CMC_MODE_TOGGLE: s_nxt.latch = !s_r.latch;
            CMC_MODE_SW_INT: s_nxt.latch = s_r.latch;
            CMC_MODE_SPECIAL:
            begin
               s_nxt.trig = 1'b1;
               s_nxt.first_rst = !use_second;
               s_nxt.second_rst = use_second;
            end
            default: s_nxt.latch = s_r.latch;
         endcase
      end
      // Register writes through byte lane 0
      if (wr_go)
      begin
         unique case (avs_address)
            CMC_OFF_CMP_LO: s_nxt.cmp_lo = wbyte;
            CMC_OFF_CMP_HI:
            begin
               if (!cmc_is_pwm(mode))
                  s_nxt.cmp_hi = wbyte;
            end
            CMC_OFF_CTRL:
            begin
               s_nxt.ctrl = wbyte & CMC_CTRL_MASK;
               if (wbyte == CMC_REG_RST)
                  s_nxt.latch = 1'b0;
            end
            CMC_OFF_TSEL_A:
            begin
               // The reserved select code is refused; the old field stays
               s_nxt.tsel_a = wbyte & CMC_TSEL_A_MASK;
               if (wbyte[1:0] == CMC_TSEL_RESERVED)
                  s_nxt.tsel_a[1:0] = s_r.tsel_a[1:0];
            end
            CMC_OFF_TSEL_B: s_nxt.tsel_b = wbyte & CMC_TSEL_B_MASK;
            CMC_OFF_FLAGS: s_nxt.flags = wbyte & CMC_CHAN_MASK;
            CMC_OFF_ENABLES: s_nxt.enables = wbyte & CMC_CHAN_MASK;
            CMC_OFF_PRIOS: s_nxt.prios = wbyte & CMC_CHAN_MASK;
            CMC_OFF_IRQ_MASK: s_nxt.irq_mask = wbyte[1:0] & CMC_IRQ_MASK_W;
            default: s_nxt.latch = s_nxt.latch;
         endcase
      end
      // Reading the status register clears it
      if (rd_go && avs_address == CMC_OFF_IRQ_STAT)
         s_nxt.irq_stat = 2'h0;
      // Hardware sets win over any clear in the same cycle
      if (act)
      begin
         s_nxt.flags[CMC_CHAN_BIT] = 1'b1;
         s_nxt.irq_stat[CMC_STAT_MATCH] = 1'b1;
         if (mode == CMC_MODE_SPECIAL)
            s_nxt.irq_stat[CMC_STAT_TRIG] = 1'b1;
      end
      // Pin follows the latch in the drive modes, the PWM level, else the port latch
      if (mode == CMC_MODE_SET_HIGH || mode == CMC_MODE_SET_LOW || mode == CMC_MODE_TOGGLE)
         s_nxt.pin = s_nxt.latch;
      else if (cmc_is_pwm(mode))
         s_nxt.pin = pwm_level;
      else
         s_nxt.pin = port_data_latch;
      s_nxt.pin_oe = !pin_direction_bit;
      // Interrupt outputs
      s_nxt.chan_int = s_nxt.flags[CMC_CHAN_BIT] && s_nxt.enables[CMC_CHAN_BIT];
      s_nxt.chan_prio = s_nxt.prios[CMC_CHAN_BIT];
      s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
   end

   // State register; waitrequest idles high
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
         s_r.wait_r <= 1'b1;
      end
      else
         s_r <= s_nxt;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   flag_on_match_a: assert property (act |=> s_r.flags[CMC_CHAN_BIT])
      else $error("event flag not set on match");
   drive_high_a: assert property (act && mode == CMC_MODE_SET_HIGH && !wr_go
         |=> s_r.latch && s_r.pin)
      else $error("pin not driven high");
   drive_low_a: assert property (act && mode == CMC_MODE_SET_LOW && !wr_go
         |=> !s_r.latch && !s_r.pin)
      else $error("pin not driven low");
   toggle_pin_a: assert property (act && mode == CMC_MODE_TOGGLE && !wr_go
         |=> s_r.latch != $past(s_r.latch))
      else $error("pin not toggled");
   swint_pin_a: assert property (act && mode == CMC_MODE_SW_INT && !wr_go
         |=> $stable(s_r.latch))
      else $error("latch moved in interrupt-only mode");
   trigger_pulse_a: assert property (act && mode == CMC_MODE_SPECIAL
         |=> special_event_trigger ##1 !special_event_trigger)
      else $error("trigger not a single pulse");
   timer_reset_a: assert property (special_event_trigger
         |-> (first_timer_reset != second_timer_reset)
         && (second_timer_reset == $past(use_second)))
      else $error("wrong timer reset");
   trigger_only_a: assert property (special_event_trigger
         |-> $past(mode) == CMC_MODE_SPECIAL)
      else $error("trigger outside trigger mode");
   clear_latch_a: assert property (wr_go && avs_address == CMC_OFF_CTRL
         && wbyte == 8'h00 |=> !s_r.latch)
      else $error("latch not cleared by zero write");
   ctrl_read_a: assert property (rd_go && avs_address == CMC_OFF_CTRL
         |-> avs_readdata[31:6] == 26'h0)
      else $error("unimplemented control bits read set");
   tsel_res_a: assert property (s_r.tsel_a[1:0] != CMC_TSEL_RESERVED)
      else $error("reserved timer select stored");
   flag_hold_a: assert property (s_r.flags[CMC_CHAN_BIT]
         && !(wr_go && avs_address == CMC_OFF_FLAGS)
         |=> s_r.flags[CMC_CHAN_BIT])
      else $error("event flag lost without software clear");
   chan_irq_a: assert property (s_r.flags[CMC_CHAN_BIT] && s_r.enables[CMC_CHAN_BIT]
         && !wr_go |=> channel_event_irq)
      else $error("enabled event flag not delivered");
   answer_time_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");

   toggle_c: cover property (act && mode == CMC_MODE_TOGGLE);
   trigger_c: cover property (act && mode == CMC_MODE_SPECIAL && use_second);
   set_clear_c: cover property (act && wr_go && avs_address == CMC_OFF_FLAGS);
   pwm_c: cover property (cmc_is_pwm(mode) && channel_output_pin);

endmodule

/* File: src/cmc_match_detect.sv */
// Equality detector between the compare value and the selected timer pair
`timescale 1ns/10ps
module cmc_match_detect
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Compare inputs
   input wire logic enable,
   input wire logic [15:0] compare_value,
   input wire logic [15:0] first_count,
   input wire logic [15:0] second_count,
   input wire logic use_second,
   // Result
   output logic hit
);
   import cmc_pkg::*;

   cmc_det_s s_r;
   cmc_det_s s_nxt;
   logic equal;

   // A prescaled timer may sit on the value for many clocks; only the first one counts
   assign equal = enable && (compare_value == (use_second ? second_count : first_count));
   assign hit = equal && !s_r.eq_prev;

   // Next state
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.eq_prev = equal;
   end

   // State register
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   match_hit_a: assert property (equal && !$past(equal) |-> hit)
      else $error("match entry not flagged");
   single_hit_a: assert property (hit |=> !hit)
      else $error("match flagged twice in a row");

endmodule

/* File: src/cmc_pkg.sv */
// Shared constants, types and helpers for the compare match channel
package cmc_pkg;

   // Register byte offsets on the Avalon-MM slave (one aligned word each)
   localparam logic [7:0] CMC_OFF_CMP_LO = 8'h00;
   localparam logic [7:0] CMC_OFF_CMP_HI = 8'h04;
   localparam logic [7:0] CMC_OFF_CTRL = 8'h08;
   localparam logic [7:0] CMC_OFF_TSEL_A = 8'h0c;
   localparam logic [7:0] CMC_OFF_TSEL_B = 8'h10;
   localparam logic [7:0] CMC_OFF_FLAGS = 8'h14;
   localparam logic [7:0] CMC_OFF_ENABLES = 8'h18;
   localparam logic [7:0] CMC_OFF_PRIOS = 8'h1c;
   localparam logic [7:0] CMC_OFF_IRQ_STAT = 8'h20;
   localparam logic [7:0] CMC_OFF_IRQ_MASK = 8'h24;

   // Implemented bits; everything else reads as zero
   localparam logic [7:0] CMC_CTRL_MASK = 8'h3f;
   localparam logic [7:0] CMC_TSEL_A_MASK = 8'hd7;
   localparam logic [7:0] CMC_TSEL_B_MASK = 8'h17;
   localparam logic [7:0] CMC_CHAN_MASK = 8'h02;
   localparam logic [1:0] CMC_IRQ_MASK_W = 2'h3;

   // Field positions
   localparam int unsigned CMC_CHAN_BIT = 1;
   localparam int unsigned CMC_DUTY_LSB = 4;
   localparam int unsigned CMC_STAT_MATCH = 0;
   localparam int unsigned CMC_STAT_TRIG = 1;

   // Reset value and reserved timer select code
   localparam logic [7:0] CMC_REG_RST = 8'h00;
   localparam logic [1:0] CMC_TSEL_RESERVED = 2'h3;

   // Compare modes of the four-bit mode select field
   typedef enum logic [3:0] {
      CMC_MODE_OFF = 4'b0000,
      CMC_MODE_TOGGLE = 4'b0010,
      CMC_MODE_SET_HIGH = 4'b1000,
      CMC_MODE_SET_LOW = 4'b1001,
      CMC_MODE_SW_INT = 4'b1010,
      CMC_MODE_SPECIAL = 4'b1011
   } cmc_mode_e;

   // Time base of the PWM path: 8-bit timer joined with 2 prescale bits
   typedef struct packed {
      logic [9:0] base;
      logic period_end;
   } cmc_pwm_time_s;

   // Whole state of the top module
   typedef struct packed {
      logic wait_r;
      logic [31:0] rdata;
      logic [7:0] cmp_lo;
      logic [7:0] cmp_hi;
      logic [7:0] ctrl;
      logic [7:0] tsel_a;
      logic [7:0] tsel_b;
      logic [7:0] flags;
      logic [7:0] enables;
      logic [7:0] prios;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic latch;
      logic pin;
      logic pin_oe;
      logic trig;
      logic first_rst;
      logic second_rst;
      logic chan_int;
      logic chan_prio;
      logic irq;
   } cmc_state_s;

   // State of the match detector
   typedef struct packed {
      logic eq_prev;
   } cmc_det_s;

   // State of the PWM generator
   typedef struct packed {
      logic [9:0] shadow;
      logic level;
   } cmc_pwm_s;

   // PWM modes occupy the codes 11xx
   function automatic logic cmc_is_pwm(input logic [3:0] m);
      return m[3:2] == 2'b11;
   endfunction

   // Modes in which a match acts
   function automatic logic cmc_is_compare(input logic [3:0] m);
      return m == CMC_MODE_TOGGLE || m == CMC_MODE_SET_HIGH || m == CMC_MODE_SET_LOW
         || m == CMC_MODE_SW_INT || m == CMC_MODE_SPECIAL;
   endfunction

   // Timer select: 00 first timer, 01 and 10 second timer
   function automatic logic cmc_use_second(input logic [1:0] sel);
      return sel == 2'b01 || sel == 2'b10;
   endfunction

endpackage

/* File: src/cmc_pwm_gen.sv */
// Double-buffered PWM output with up to 10-bit duty resolution
`timescale 1ns/10ps
module cmc_pwm_gen
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Control
   input wire logic enable,
   input wire logic [9:0] duty,
   input wire cmc_pkg::cmc_pwm_time_s pwm_time,
   // Output level
   output logic level
);
   import cmc_pkg::*;

   cmc_pwm_s s_r;
   cmc_pwm_s s_nxt;

   assign level = s_r.level;

   // Duty is taken only at period end so a mid-period write cannot glitch the pulse
   always_comb
   begin
      s_nxt = s_r;
      if (!enable)
         s_nxt.level = 1'b0;
      else if (pwm_time.period_end)
      begin
         s_nxt.shadow = duty;
         s_nxt.level = (duty != 10'h000);
      end
      else if (s_r.level && s_r.shadow == pwm_time.base)
         s_nxt.level = 1'b0;
   end

   // State register
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   zero_duty_a: assert property (enable && pwm_time.period_end && duty == 10'h000 |=> !level)
      else $error("pwm set with zero duty");
   duty_end_a: assert property (enable && level && !pwm_time.period_end
         && s_r.shadow == pwm_time.base |=> !level)
      else $error("pwm not cleared at duty end");

endmodule

/* File: testbench/cmc_far_side.sv */
// Far side model: two synchronous timers and the load on the pin
`timescale 1ns/10ps
module cmc_far_side
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Timer pairs
   input wire logic clr,
   input wire logic first_timer_reset,
   input wire logic second_timer_reset,
   output logic [15:0] first_count,
   output logic [15:0] second_count,
   // Pin load
   input wire logic pin,
   input wire logic pin_oe,
   output logic pin_level
);
   // Timers step on the system clock only, so no asynchronous count
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         first_count <= 16'h0000;
         second_count <= 16'h0000;
      end
      else
      begin
         first_count <= (clr || first_timer_reset) ? 16'h0000 : first_count + 16'h0001;
         second_count <= (clr || second_timer_reset) ? 16'h0000 : second_count + 16'h0001;
      end
   end
   // Pull-down holds the wire low while nothing drives it
   assign pin_level = pin_oe ? pin : 1'b0;
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the compare match channel
`timescale 1ns/10ps
module tb;
   import cmc_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] adr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [3:0] be = 4'h0;
   logic [31:0] rdat;
   logic wtq;
   logic [15:0] c1;
   logic [15:0] c2;
   logic [15:0] v = 16'h0;
   cmc_pwm_time_s pt = '0;
   logic fr, sr, trg, pin, oe, eirq, hp, irq, lvl;
   logic pdl = 1'b0;
   logic dir = 1'b1;
   logic clr = 1'b1;
   logic [3:0] ev;
   logic [31:0] expq[$];
   logic [3:0] md [4] = '{CMC_MODE_SET_HIGH, CMC_MODE_SET_LOW, CMC_MODE_TOGGLE, CMC_MODE_TOGGLE};
   logic ex [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
   integer seed = 32'hd7b005c0;
   int err_count = 0;
   int total_checks = 0;
   int hc;
   assign ev = {trg, eirq, irq, lvl};

   cmc_channel cmc_channel_inst (.sys_clk(sys_clk), .rst(rst), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
      .avs_readdata(rdat), .avs_waitrequest(wtq), .first_timer_pair(c1),
      .second_timer_pair(c2), .pwm_time(pt), .first_timer_reset(fr),
      .second_timer_reset(sr), .special_event_trigger(trg), .port_data_latch(pdl),
      .pin_direction_bit(dir), .channel_output_pin(pin), .channel_output_pin_oe(oe),
      .channel_event_irq(eirq), .channel_event_high_prio(hp), .irq(irq));
   cmc_far_side cmc_far_side_inst (.sys_clk(sys_clk), .rst(rst), .clr(clr),
      .first_timer_reset(fr), .second_timer_reset(sr), .first_count(c1),
      .second_count(c2), .pin(pin), .pin_oe(oe), .pin_level(lvl));

   // Free-running 100 MHz clock
   always #5 sys_clk = ~sys_clk;

   // PWM time base of 16 steps, period end on the last step
   always @(posedge sys_clk)
   begin
      pt.base <= (pt.base == 10'h00f) ? 10'h000 : pt.base + 10'h001;
      pt.period_end <= (pt.base == 10'h00e);
   end

   task automatic final_report();
      $display("checks=%0d mismatches=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // A wait that runs out counts as a mismatch and ends the run
   task automatic tmo();
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
      final_report();
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   // One Avalon-MM transfer, held until waitrequest is seen low
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
      input logic [3:0] b);
      int n;
      n = 0;
      adr <= a;
      rd <= ~w;
      wr <= w;
      wd <= {24'h0, d};
      be <= b;
      @(posedge sys_clk);
      while (wtq !== 1'b0 && n < 20)
      begin
         @(posedge sys_clk);
         n++;
      end
      if (n == 20)
         tmo();
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wrx(input logic [7:0] a, input logic [7:0] d);
      bus(a, 1'b1, d, 4'h1);
   endtask

   task automatic rdx(input logic [7:0] a, input logic [7:0] e);
      expq.push_back({24'h0, e});
      bus(a, 1'b0, 8'h00, 4'h1);
   endtask

   // Wait for one of the watched outputs, bounded
   task automatic wev(input int i);
      int n;
      n = 0;
      @(posedge sys_clk);
      while (ev[i] !== 1'b1 && n < 600)
      begin
         @(posedge sys_clk);
         n++;
      end
      if (n == 600)
         tmo();
   endtask

   // Random compare value: high byte zero, low byte at least 20h, so no half-written
   // value can meet the timer held at 0
   task automatic setv();
      v = 16'h0020 + 16'($random(seed) & 32'h7f);
      wrx(CMC_OFF_CMP_LO, v[7:0]);
      wrx(CMC_OFF_CMP_HI, v[15:8]);
   endtask

   // Read data is compared in the order the reads were issued
   always @(posedge sys_clk)
      if (rd && wtq === 1'b0)
         chk(rdat, expq.pop_front());

   initial
   begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      for (int a = 0; a <= 40; a += 4)
         rdx(8'(a), 8'h00);
      wrx(CMC_OFF_CTRL, 8'hff);
      rdx(CMC_OFF_CTRL, 8'h3f);
      wrx(CMC_OFF_TSEL_A, 8'hff);
      rdx(CMC_OFF_TSEL_A, 8'hd4);
      wrx(CMC_OFF_TSEL_B, 8'hff);
      rdx(CMC_OFF_TSEL_B, 8'h17);
      wrx(CMC_OFF_FLAGS, 8'hff);
      rdx(CMC_OFF_FLAGS, 8'h02);
      bus(CMC_OFF_CMP_LO, 1'b1, 8'haa, 4'h0);
      wrx(8'h28, 8'h55);
      rdx(CMC_OFF_CMP_LO, 8'h00);
      rdx(8'h28, 8'h00);
      wrx(CMC_OFF_CTRL, 8'h00);
      wrx(CMC_OFF_TSEL_A, 8'h00);
      wrx(CMC_OFF_FLAGS, 8'h00);
      chk(32'(lvl), 32'h0);
      dir <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk(32'(oe), 32'h1);
      $display("registers done");
      // Pin actions; the last one follows a zero write of control
      wrx(CMC_OFF_IRQ_MASK, 8'h01);
      for (int i = 0; i < 4; i++)
      begin
         clr <= 1'b1;
         if (i == 3)
            wrx(CMC_OFF_CTRL, 8'h00);
         setv();
         wrx(CMC_OFF_CTRL, {4'h0, md[i]});
         clr <= 1'b0;
         wev(1);
         chk(32'(lvl), 32'(ex[i]));
         chk(32'(c1), 32'(v + 16'h0001));
         rdx(CMC_OFF_IRQ_STAT, 8'h01);
         rdx(CMC_OFF_FLAGS, 8'h02);
         wrx(CMC_OFF_FLAGS, 8'h00);
      end
      $display("pin modes done");
      // Interrupt only, with the summary line masked
      clr <= 1'b1;
      wrx(CMC_OFF_CTRL, 8'h00);
      pdl <= 1'b1;
      wrx(CMC_OFF_IRQ_MASK, 8'h00);
      wrx(CMC_OFF_ENABLES, 8'h02);
      wrx(CMC_OFF_PRIOS, 8'h02);
      wrx(CMC_OFF_CTRL, {4'h0, CMC_MODE_SW_INT});
      setv();
      clr <= 1'b0;
      wev(2);
      chk(32'(lvl), 32'h1);
      chk(32'(irq), 32'h0);
      chk(32'(hp), 32'h1);
      rdx(CMC_OFF_IRQ_STAT, 8'h01);
      wrx(CMC_OFF_FLAGS, 8'h00);
      @(posedge sys_clk);
      chk(32'(eirq), 32'h0);
      $display("software interrupt done");
      // Special event trigger on all three timer selections
      pdl <= 1'b0;
      for (int s = 0; s < 3; s++)
      begin
         clr <= 1'b1;
         wrx(CMC_OFF_TSEL_A, 8'(s));
         wrx(CMC_OFF_CTRL, {4'h0, CMC_MODE_SPECIAL});
         setv();
         clr <= 1'b0;
         wev(3);
         chk(32'(sr), 32'(s != 0));
         chk(32'(fr), 32'(s == 0));
         @(posedge sys_clk);
         chk(32'(trg), 32'h0);
         chk(32'((s == 0) ? c1 : c2), 32'h0);
         rdx(CMC_OFF_IRQ_STAT, 8'h03);
      end
      $display("special trigger done");
      // PWM: duty 8 of 16, then duty 0 keeps the pin low
      clr <= 1'b1;
      wrx(CMC_OFF_CMP_LO, 8'h02);
      wrx(CMC_OFF_CTRL, 8'h0c);
      wrx(CMC_OFF_CMP_HI, 8'h55);
      rdx(CMC_OFF_CMP_HI, v[15:8]);
      for (int k = 0; k < 2; k++)
      begin
         repeat (32) @(posedge sys_clk);
         hc = 0;
         repeat (32)
         begin
            @(posedge sys_clk);
            hc += int'(lvl);
         end
         if (k == 0)
            chk(32'(hc >= 14 && hc <= 22), 32'h1);
         else
            chk(32'(hc), 32'h0);
         wrx(CMC_OFF_CMP_LO, 8'h00);
      end
      $display("pwm done");
      final_report();
   end
endmodule
